// ---- hdl/acs_pkg.sv ----
// Shared constants, types and functions of the converter sequencer
package acs_pkg;

  // Register indexes; the bus byte address is four times the index
  localparam logic [15:0] CTRL_INDEX      = 16'hfe58;
  localparam logic [15:0] MODE_INDEX      = 16'hfe59;
  localparam logic [15:0] RESULT_LO_INDEX = 16'hfe5a;
  localparam logic [15:0] RESULT_HI_INDEX = 16'hfe5b;

  // Reset values
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] MODE_RESET      = 8'h00;
  localparam logic [7:0] RESULT_LO_RESET = 8'h00;
  localparam logic [7:0] RESULT_HI_RESET = 8'h00;

  // Control register fields
  localparam int CTRL_CHAN_MSB  = 7;
  localparam int CTRL_CHAN_LSB  = 4;
  localparam int CTRL_FIXED_BIT = 3;
  localparam int CTRL_GO_BIT    = 2;
  localparam int CTRL_DONE_BIT  = 1;
  localparam int CTRL_IE_BIT    = 0;

  // Mode register fields
  localparam int MODE_RES_BIT    = 6;
  localparam int MODE_TIME_MID   = 1;
  localparam int MODE_TIME_LSB   = 0;

  // Low result byte fields
  localparam int LO_DATA_MSB    = 7;
  localparam int LO_DATA_LSB    = 4;
  localparam int LO_FIXED_MSB   = 3;
  localparam int LO_FIXED_LSB   = 1;
  localparam int LO_TIME_MSB    = 0;

  // Conversion time formula terms, in thirds of a cycle-clock period
  localparam logic [14:0] BASE_12BIT = 15'h0034;
  localparam logic [14:0] BASE_8BIT  = 15'h0020;
  localparam logic [14:0] TIME_ADD   = 15'h0002;

  // One third of the cycle-clock period, and the system clock period
  localparam int TICK_NS     = 50;
  localparam int CLOCK_NS    = 50;
  localparam int TICK_CYCLES = (TICK_NS + CLOCK_NS - 1) / CLOCK_NS;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } acs_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } acs_wb_rsp_type;

  typedef enum logic [1:0] {ACS_IDLE, ACS_CONVERT} acs_state_type;

  // Length of one conversion in thirds of a cycle-clock period
  function automatic logic [14:0] acs_conv_ticks(input logic [2:0] code,
                                                 input logic       res8,
                                                 input logic       dbl);
    logic [14:0] ticks;
    ticks = ((res8 ? BASE_8BIT : BASE_12BIT) << code) + TIME_ADD;
    return dbl ? (ticks << 1) : ticks;
  endfunction : acs_conv_ticks

endpackage : acs_pkg

// ---- hdl/acs_tick_divider.sv ----
// Enable pulse at three times the cycle-clock rate
`timescale 1ns/10ps
`default_nettype none
module acs_tick_divider
  import acs_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  output logic      tick
);

  logic [7:0] divCount;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      divCount <= 8'h00;
    end else if (divCount == 8'(TICK_CYCLES - 1)) begin
      divCount <= 8'h00;
    end else begin
      divCount <= divCount + 8'h01;
    end
  end

  assign tick = (divCount == 8'(TICK_CYCLES - 1));

endmodule : acs_tick_divider
`default_nettype wire

// ---- hdl/acs_conv_timer.sv ----
// Down counter that times one conversion in ticks
`timescale 1ns/10ps
`default_nettype none
module acs_conv_timer
  import acs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic        load,
  input  wire logic        abort,
  input  wire logic [14:0] loadTicks,
  output logic             running,
  output logic             expired
);

  logic [14:0] remain;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      remain <= 15'h0000;
    end else if (abort) begin
      remain <= 15'h0000;
    end else if (load) begin
      remain <= loadTicks;
    end else if (tick && remain != 15'h0000) begin
      remain <= remain - 15'h0001;
    end
  end

  assign running = (remain != 15'h0000);
  assign expired = tick && (remain == 15'h0001) && !abort && !load;

endmodule : acs_conv_timer
`default_nettype wire

// ---- hdl/acs_sequencer.sv ----
// Conversion sequencer of the successive-approximation converter
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           reset,
  input  wire acs_wb_req_type wbReq,
  output acs_wb_rsp_type      wbRsp,
  input  wire logic [11:0]    sarData,
  output logic [3:0]          channelSel,
  output logic                convRun,
  output logic                resolution8,
  output logic                convIrq
);

  // Register state
  logic [7:0]    convControlReg;
  logic [7:0]    convModeReg;
  logic [7:0]    resultLowReg;
  logic [7:0]    resultHighReg;
  logic          warmupPending;
  logic [14:0]   loadedTicks;
  acs_state_type state;

  // Bus decode
  logic          busReq;
  logic          busWrite;
  logic [15:0]   regIndex;
  logic          hitCtrl;
  logic          hitMode;
  logic          hitLow;
  logic          hitHigh;
  logic [7:0]    writeByte;
  logic [7:0]    next_readByte;

  // Sequencing
  logic          tick;
  logic          startConv;
  logic          abortConv;
  logic          finish;
  logic          timerRunning;
  logic [2:0]    timeCode;
  logic          next_double;
  logic [14:0]   next_ticks;

  // Bus slave: one wait state, ack dropped in the cycle after it is given
  assign busReq    = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign busWrite  = busReq && wbReq.we && wbReq.sel[0];
  assign regIndex  = wbReq.adr[17:2];
  assign writeByte = wbReq.dat[7:0];

  always_comb begin
    hitCtrl = 1'b0;
    hitMode = 1'b0;
    hitLow  = 1'b0;
    hitHigh = 1'b0;
    if (wbReq.adr[31:18] != 14'h0000 || wbReq.adr[1:0] != 2'h0) begin
      hitCtrl = 1'b0;
    end else if (regIndex == CTRL_INDEX) begin
      hitCtrl = 1'b1;
    end else if (regIndex == MODE_INDEX) begin
      hitMode = 1'b1;
    end else if (regIndex == RESULT_LO_INDEX) begin
      hitLow = 1'b1;
    end else if (regIndex == RESULT_HI_INDEX) begin
      hitHigh = 1'b1;
    end
  end

  always_comb begin
    if (hitCtrl) begin
      next_readByte = convControlReg;
    end else if (hitMode) begin
      next_readByte = convModeReg;
    end else if (hitLow) begin
      next_readByte = resultLowReg;
    end else if (hitHigh) begin
      next_readByte = resultHighReg;
    end else begin
      next_readByte = 8'h00;
    end
  end

  // Unmapped addresses still ack and read as zero so the master never hangs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wbRsp <= '0;
    end else begin
      wbRsp.ack <= busReq;
      wbRsp.dat <= busReq ? {24'h000000, next_readByte} : 32'h00000000;
    end
  end

  // Conversion time code, most significant bit lives in the low result byte
  assign timeCode = {resultLowReg[LO_TIME_MSB], convModeReg[MODE_TIME_MID],
                     convModeReg[MODE_TIME_LSB]};

  // Start on a write that sets go while idle; abort on a write that clears it
  assign startConv = busWrite && hitCtrl && writeByte[CTRL_GO_BIT] && (state == ACS_IDLE);
  assign abortConv = busWrite && hitCtrl && !writeByte[CTRL_GO_BIT]
                     && (state == ACS_CONVERT);

  assign next_double = !convModeReg[MODE_RES_BIT] && warmupPending;
  assign next_ticks  = acs_conv_ticks(timeCode, convModeReg[MODE_RES_BIT],
                                      next_double);

  acs_tick_divider u_divider (
    .clock (clock),
    .reset (reset),
    .tick  (tick)
  );

  acs_conv_timer u_timer (
    .clock     (clock),
    .reset     (reset),
    .tick      (tick),
    .load      (startConv),
    .abort     (abortConv),
    .loadTicks (next_ticks),
    .running   (timerRunning),
    .expired   (finish)
  );

  // Sequencer state; reset drops any conversion in flight
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ACS_IDLE;
    end else begin
      case (state)
        ACS_IDLE: begin
          if (startConv) begin
            state <= ACS_CONVERT;
          end
        end
        ACS_CONVERT: begin
          if (finish || abortConv) begin
            state <= ACS_IDLE;
          end
        end
        default: begin
          state <= ACS_IDLE;
        end
      endcase
    end
  end

  // Helper for checking: tick length loaded at the last start
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      loadedTicks <= 15'h0000;
    end else if (startConv) begin
      loadedTicks <= next_ticks;
    end
  end

  // Warm-up doubling pending after reset and after any 8-bit selection
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      warmupPending <= 1'b1;
    end else if (convModeReg[MODE_RES_BIT]) begin
      warmupPending <= 1'b1;
    end else if (finish) begin
      warmupPending <= 1'b0;
    end
  end

  // Control register; hardware set of done wins over a software clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      convControlReg <= CTRL_RESET;
    end else begin
      if (busWrite && hitCtrl) begin
        convControlReg[CTRL_CHAN_MSB:CTRL_CHAN_LSB] <= writeByte[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
        convControlReg[CTRL_FIXED_BIT] <= writeByte[CTRL_FIXED_BIT];
        convControlReg[CTRL_IE_BIT]    <= writeByte[CTRL_IE_BIT];
        convControlReg[CTRL_DONE_BIT]  <= writeByte[CTRL_DONE_BIT];
        convControlReg[CTRL_GO_BIT]    <= writeByte[CTRL_GO_BIT];
      end
      if (finish) begin
        convControlReg[CTRL_DONE_BIT] <= 1'b1;
        convControlReg[CTRL_GO_BIT]   <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      convModeReg <= MODE_RESET;
    end else if (busWrite && hitMode) begin
      convModeReg <= writeByte;
    end
  end

  // Result bytes; the converter writes them only at completion, and writes the low byte only in 12-bit mode
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      resultLowReg <= RESULT_LO_RESET;
    end else begin
      if (busWrite && hitLow) begin
        resultLowReg <= writeByte;
      end
      if (finish && !convModeReg[MODE_RES_BIT]) begin
        resultLowReg[LO_DATA_MSB:LO_DATA_LSB] <= sarData[3:0];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      resultHighReg <= RESULT_HI_RESET;
    end else if (finish) begin
      resultHighReg <= sarData[11:4];
    end else if (busWrite && hitHigh) begin
      resultHighReg <= writeByte;
    end
  end

  // Analog side
  assign channelSel  = convControlReg[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
  assign convRun     = (state == ACS_CONVERT);
  assign resolution8 = convModeReg[MODE_RES_BIT];
  assign convIrq     = convControlReg[CTRL_IE_BIT]
                       && convControlReg[CTRL_DONE_BIT];

  // Helper for checking: ticks elapsed in the running conversion
  logic [14:0] elapsedTicks;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      elapsedTicks <= 15'h0000;
    end else if (startConv) begin
      elapsedTicks <= 15'h0000;
    end else if (tick && state == ACS_CONVERT) begin
      elapsedTicks <= elapsedTicks + 15'h0001;
    end
  end

  a_done_clears_go: assert property (@(posedge clock) disable iff (reset)
    finish |=> convControlReg[CTRL_DONE_BIT] && !convControlReg[CTRL_GO_BIT]
               && state == ACS_IDLE)
    else $error("Completion did not set done and clear go");

  a_irq_on_done: assert property (@(posedge clock) disable iff (reset)
    finish && convControlReg[CTRL_IE_BIT] && !(busWrite && hitCtrl) |=> convIrq)
    else $error("Interrupt request missing at end of conversion");

  a_low_kept_8bit: assert property (@(posedge clock) disable iff (reset)
    finish && convModeReg[MODE_RES_BIT] && !(busWrite && hitLow) |=> $stable(resultLowReg))
    else $error("Low result byte changed in 8-bit mode");

  a_high_result: assert property (@(posedge clock) disable iff (reset)
    finish |=> resultHighReg == 8'($past(sarData) >> 4))
    else $error("High result byte not written at completion");

  a_low_nibble: assert property (@(posedge clock) disable iff (reset)
    finish && !convModeReg[MODE_RES_BIT]
    |=> resultLowReg[7:4] == 4'($past(sarData)))
    else $error("Low result nibble not written in 12-bit mode");

  a_abort_stops: assert property (@(posedge clock) disable iff (reset)
    abortConv |=> state == ACS_IDLE && !timerRunning ##1 !finish)
    else $error("Conversion kept running after go was cleared");

  a_timer_length: assert property (@(posedge clock) disable iff (reset)
    finish |-> elapsedTicks + 15'h0001 == loadedTicks)
    else $error("Conversion ended after the wrong number of ticks");

  a_double_first: assert property (@(posedge clock) disable iff (reset)
    startConv && !convModeReg[MODE_RES_BIT] && warmupPending
    |-> next_ticks == ((BASE_12BIT << timeCode) + TIME_ADD) << 1)
    else $error("First 12-bit conversion not doubled");

  a_normal_8bit: assert property (@(posedge clock) disable iff (reset)
    startConv && convModeReg[MODE_RES_BIT] |-> next_ticks == (BASE_8BIT << timeCode) + TIME_ADD)
    else $error("8-bit conversion time wrong");

  a_ratio_128: assert property (@(posedge clock) disable iff (reset)
    startConv && timeCode == 3'h7 && !convModeReg[MODE_RES_BIT] && !warmupPending
    |-> next_ticks == 15'h1a02)
    else $error("Slowest 12-bit time wrong");

  // Go bit and run state move together, so software polling go never sees a stale run
  a_run_matches_go: assert property (@(posedge clock) disable iff (reset)
    convRun == convControlReg[CTRL_GO_BIT])
    else $error("Run state and go bit disagree");

  a_done_held: assert property (@(posedge clock) disable iff (reset)
    convControlReg[CTRL_DONE_BIT] && !(busWrite && hitCtrl) |=> convControlReg[CTRL_DONE_BIT])
    else $error("Done flag cleared without a software write");

  a_start_runs: assert property (@(posedge clock) disable iff (reset)
    startConv |=> timerRunning && convRun)
    else $error("Start did not load the conversion timer");

  a_idle_no_finish: assert property (@(posedge clock) disable iff (reset)
    state == ACS_IDLE |-> !finish)
    else $error("Timer expired while no conversion was running");

  a_warm_clears: assert property (@(posedge clock) disable iff (reset)
    finish && !convModeReg[MODE_RES_BIT] |=> !warmupPending)
    else $error("Doubling still pending after a 12-bit conversion");

  a_warm_8bit: assert property (@(posedge clock) disable iff (reset)
    convModeReg[MODE_RES_BIT] |=> warmupPending)
    else $error("Doubling not armed by 8-bit selection");

  a_normal_12bit: assert property (@(posedge clock) disable iff (reset)
    startConv && !convModeReg[MODE_RES_BIT] && !warmupPending
    |-> next_ticks == (BASE_12BIT << timeCode) + TIME_ADD)
    else $error("Normal 12-bit conversion time wrong");

  a_ratio_one_8bit: assert property (@(posedge clock) disable iff (reset)
    startConv && timeCode == 3'h0 && convModeReg[MODE_RES_BIT] |-> next_ticks == 15'h0022)
    else $error("Fastest 8-bit time wrong");

  // An abort must leave the last good result in place for software
  a_abort_keeps: assert property (@(posedge clock) disable iff (reset)
    abortConv |=> $stable(resultHighReg))
    else $error("High result byte changed by an abort");

endmodule : acs_sequencer
`default_nettype wire

// ---- verification/acs_sequencer_tb.sv ----
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  import acs_pkg::*;

  localparam logic [31:0] CTRL_ADR = {14'h0000, CTRL_INDEX, 2'b00};
  localparam logic [31:0] MODE_ADR = {14'h0000, MODE_INDEX, 2'b00};
  localparam logic [31:0] LO_ADR   = {14'h0000, RESULT_LO_INDEX, 2'b00};
  localparam logic [31:0] HI_ADR   = {14'h0000, RESULT_HI_INDEX, 2'b00};

  logic           clock;
  logic           reset;
  acs_wb_req_type wbReq;
  acs_wb_rsp_type wbRsp;
  logic [11:0]    sarData;
  logic [3:0]     channelSel;
  logic           convRun;
  logic           resolution8;
  logic           convIrq;
  int             fails;
  int             totalChecks;
  int             cycles;
  logic [31:0]    rnd;
  logic [31:0]    rd;
  int             loModel;
  int             hiModel;
  int             warm;

  acs_sequencer DUT (
    .clock       (clock),
    .reset       (reset),
    .wbReq       (wbReq),
    .wbRsp       (wbRsp),
    .sarData     (sarData),
    .channelSel  (channelSel),
    .convRun     (convRun),
    .resolution8 (resolution8),
    .convIrq     (convIrq)
  );

  always #25 clock = ~clock;

  // Hang guard, well above the longest expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      $display("Error at %0t: timeout", $time);
      wrap_up();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Classic single cycle; no fixed latency assumed, the timeout ends a hang
  task automatic bus(input logic we, input logic [31:0] adr, input logic [7:0] wd);
    @(posedge clock);
    wbReq <= '{1'b1, 1'b1, we, 4'h1, adr, {24'h000000, wd}};
    forever begin
      @(posedge clock);
      if (wbRsp.ack === 1'b1) break;
    end
    rd = wbRsp.dat;
    wbReq <= '0;
  endtask : bus

  task automatic rdchk(input logic [31:0] adr, input logic [31:0] exp, input string what);
    bus(1'b0, adr, 8'h00);
    chk(rd, exp, what);
  endtask : rdchk

  task automatic conv(input logic res8, input logic [2:0] code, input logic [3:0] chan,
                      input logic ie);
    int n;
    int cnt;
    @(posedge clock);
    rnd = xs(rnd);
    sarData <= rnd[11:0];
    bus(1'b1, MODE_ADR, {1'b0, res8, 4'h0, code[1:0]});
    if (res8) warm = 1;
    loModel = (loModel & 32'hf0) | code[2];
    bus(1'b1, LO_ADR, loModel[7:0]);
    bus(1'b1, CTRL_ADR, {chan, 3'b010, ie});
    n = ((res8 ? 32 : 52) << code) + 2;
    if (!res8 && warm != 0) n = n * 2;
    #1;
    cnt = 1;
    chk(convRun, 1, "run");
    while (convRun === 1'b1) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    chk(cnt, n, "ticks");
    hiModel = rnd[11:4];
    if (!res8) begin
      loModel = {rnd[3:0], 3'b000, code[2]};
      warm = 0;
    end
    chk(convIrq, ie, "irq");
    chk(channelSel, chan, "chan");
    chk(resolution8, res8, "res");
    rdchk(CTRL_ADR, {chan, 3'b001, ie}, "ctrl");
    rdchk(HI_ADR, hiModel, "high");
    rdchk(LO_ADR, loModel, "low");
    bus(1'b1, CTRL_ADR, {chan, 3'b000, ie});
    #1;
    chk(convIrq, 0, "irq clear");
    $display("Test conversion res8=%0b code=%0d done", res8, code);
  endtask : conv

  task automatic zero_regs;
    rdchk(CTRL_ADR, 0, "ctrl reset");
    rdchk(MODE_ADR, 0, "mode reset");
    rdchk(LO_ADR, 0, "low reset");
    rdchk(HI_ADR, 0, "high reset");
  endtask : zero_regs

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    wbReq = '0;
    sarData = 12'h000;
    rnd = 32'd95488;
    fails = 0;
    totalChecks = 0;
    cycles = 0;
    loModel = 0;
    hiModel = 0;
    warm = 1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    zero_regs();
    // Unmapped and misaligned places answer but hold nothing
    bus(1'b1, 32'h0003f970, 8'hff);
    rdchk(32'h0003f970, 0, "unmapped");
    rdchk(32'h0003f961, 0, "misaligned");
    $display("Test registers done");
    conv(1'b0, 3'd0, 4'h5, 1'b1);
    conv(1'b0, 3'd0, 4'hd, 1'b0);
    for (int c = 0; c < 8; c++) begin
      conv(1'b1, c[2:0], c[3:0], c[0]);
    end
    // Abort during a long conversion: no done, results kept
    @(posedge clock);
    sarData <= 12'h5a5;
    bus(1'b1, CTRL_ADR, 8'h25);
    repeat (10) @(posedge clock);
    bus(1'b1, CTRL_ADR, 8'h21);
    #1;
    chk(convRun, 0, "abort run");
    repeat (50) @(posedge clock);
    rdchk(CTRL_ADR, 32'h21, "abort ctrl");
    rdchk(HI_ADR, hiModel, "abort high");
    rdchk(LO_ADR, loModel, "abort low");
    chk(convIrq, 0, "abort irq");
    $display("Test abort done");
    conv(1'b0, 3'd0, 4'h3, 1'b1);
    conv(1'b0, 3'd3, 4'h9, 1'b0);
    conv(1'b0, 3'd7, 4'h1, 1'b1);
    // Reset in mid-conversion halts it and clears every register
    bus(1'b1, MODE_ADR, 8'h00);
    bus(1'b1, CTRL_ADR, 8'h05);
    repeat (20) @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    #1;
    chk(convRun, 0, "reset run");
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    loModel = 0;
    hiModel = 0;
    warm = 1;
    zero_regs();
    conv(1'b0, 3'd0, 4'h1, 1'b1);
    rdchk(CTRL_ADR, 32'h11, "go low at end");
    $display("Test reset done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
